// *** tb.sv ***
// testbench for uart_addr_match: bus tasks, serial frames both ways, address filtering.
// assumes uart_am_node as far end and a timer overflow pulse every second clock.
`timescale 1ns/10ps
`default_nettype none
module tb;
   localparam logic [4:0] CTL = uart_am_pkg::OFF_SERIAL_CONTROL;
   localparam logic [4:0] DAT = uart_am_pkg::OFF_SERIAL_DATA;
   localparam logic [4:0] PWR = uart_am_pkg::OFF_POWER_CONTROL;
   localparam logic [4:0] SAD = uart_am_pkg::OFF_SLAVE_ADDRESS;
   localparam logic [4:0] MSK = uart_am_pkg::OFF_SLAVE_MASK;
   logic        ref_clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic [4:0]  address_i = 5'h00;
   logic        read_i = 1'b0;
   logic        write_i = 1'b0;
   logic [31:0] writedata_i = 32'h0;
   logic [31:0] readdata_o;
   logic        waitrequest_o;
   logic        overflow = 1'b0;
   logic        rx_line;
   logic        tx_line;
   int          num_errors = 0;
   int          total_checks = 0;
   logic [7:0]  rv;
   logic [10:0] fr;
   logic [10:0] am [4] = '{11'h0c2, 11'h2c1, 11'h5c2, 11'h7ff};
   ////////////////////////////////////////////////////////////
   always #25 ref_clk_i = ~ref_clk_i;
   always @(posedge ref_clk_i) overflow <= ~overflow;
   uart_addr_match dut_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .address_i(address_i), .read_i(read_i),
      .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(4'h1), .readdata_o(readdata_o),
      .waitrequest_o(waitrequest_o), .timer_overflow_i(overflow), .serial_in_pin_i(rx_line),
      .serial_out_pin_o(tx_line));
   uart_am_node node_u (.clk_i(ref_clk_i), .tx_i(tx_line), .rx_o(rx_line));
   task automatic complete_run();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      address_i <= a;
      writedata_i <= {24'h0, d};
      write_i <= wr;
      read_i <= !wr;
      // only the watchdog ends a wait that never gets its answer
      do begin
         @(posedge ref_clk_i);
      end while (waitrequest_o !== 1'b0);
      rv = readdata_o[7:0];
      write_i <= 1'b0;
      read_i <= 1'b0;
   endtask
   task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %0t register read %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_frame(input logic [10:0] got, input logic [10:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %0t line frame %h expected %h", $time, got, exp);
      end
   endtask
   initial begin
      repeat (20000) @(posedge ref_clk_i);
      num_errors++;
      complete_run();
   end
   initial begin
      repeat (5) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      bus(0, SAD, 0);
      chk_reg(rv, 8'h00);
      bus(0, MSK, 0);
      chk_reg(rv, 8'h00);
      bus(0, 5'h14, 0);
      chk_reg(rv, 8'h00);
      // 8-bit mode, doubler set: 32 clocks per bit
      bus(1, PWR, 8'h80);
      bus(1, CTL, 8'h50);
      fork
         node_u.recv(fr, 10, 32);
         bus(1, DAT, 8'ha5);
      join
      chk_frame(fr, {2'b01, 8'ha5, 1'b0});
      repeat (40) @(posedge ref_clk_i);
      bus(0, CTL, 0);
      chk_reg(rv, 8'h52);
      bus(1, CTL, 8'h50);
      // second frame lands while the done flag is still set
      node_u.send({2'b01, 8'h3c, 1'b0}, 10, 32);
      node_u.send({2'b01, 8'h5a, 1'b0}, 10, 32);
      bus(0, CTL, 0);
      chk_reg(rv, 8'h55);
      bus(0, DAT, 0);
      chk_reg(rv, 8'h3c);
      bus(1, CTL, 8'h50);
      node_u.send(11'h000, 1, 4);
      repeat (64) @(posedge ref_clk_i);
      bus(0, CTL, 0);
      chk_reg(rv, 8'h50);
      node_u.send({2'b00, 8'h81, 1'b0}, 10, 32);
      bus(1, PWR, 8'hc0);
      bus(0, CTL, 0);
      chk_reg(rv, 8'hd1);
      bus(1, CTL, 8'hd0);
      node_u.send({2'b01, 8'h81, 1'b0}, 10, 32);
      bus(0, CTL, 0);
      chk_reg(rv, 8'hd5);
      bus(1, CTL, 8'h50);
      bus(0, CTL, 0);
      chk_reg(rv, 8'h50);
      // 8-bit address mode: missing stop drops the frame, error still flagged
      bus(1, CTL, 8'h70);
      node_u.send({2'b00, 8'h81, 1'b0}, 10, 32);
      bus(0, CTL, 0);
      chk_reg(rv, 8'hf0);
      // doubler set: fixed 9-bit 16 clocks per bit, timer 9-bit 32
      bus(1, PWR, 8'h80);
      for (int i = 0; i < 3; i++) begin
         bus(1, CTL, i[1] ? 8'hd8 : 8'h90 | (i[0] ? 8'h08 : 8'h00));
         bus(0, CTL, 0);
         chk_reg(rv & 8'hf8, i[1] ? 8'hd8 : 8'h90 | (i[0] ? 8'h08 : 8'h00));
         fork
            node_u.recv(fr, 11, i[1] ? 32 : 16);
            bus(1, DAT, 8'h96);
         join
         chk_frame(fr, {1'b1, i[1] | i[0], 8'h96, 1'b0});
         repeat (40) @(posedge ref_clk_i);
      end
      // fixed 9-bit, doubler clear: 32 clocks per bit
      bus(1, PWR, 8'h00);
      // rows: accept, stop, ninth, data
      bus(1, SAD, 8'hc0);
      bus(1, MSK, 8'hfd);
      for (int i = 0; i < 4; i++) begin
         bus(1, CTL, 8'hb0);
         node_u.send({am[i][9:0], 1'b0}, 11, 32);
         bus(0, CTL, 0);
         chk_reg(rv & 8'h01, {7'h0, am[i][10]});
         bus(0, DAT, 0);
         if (am[i][10])
            chk_reg(rv, am[i][7:0]);
      end
      complete_run();
   end
endmodule // tb
`default_nettype wire

// *** uart_addr_match.sv ***
// async serial port with 8-bit and 9-bit frames, 16x oversampled receive with
// majority vote, framing error and automatic multiprocessor address recognition.
// assumes an avalon-mm master, a timer overflow pulse and pins synchronous to ref_clk_i.
//
// Functional notes
// (RULE1) 8-bit frame: start, 8 lsb-first, stop
// (RULE2) data write requests send, aligned to rollover
// (RULE3) start bit, then data, then first shift
// (RULE4) 8-bit: zeros in, end at tenth rollover
// (RULE5) 9-bit frame adds programmable ninth bit
// (RULE6) 9-bit: first shift loads stop one
// (RULE7) 9-bit: end at eleventh rollover
// (RULE8) fixed 9-bit rate /16 or /32; variable timer
// (RULE9) 16x sampling; edge resets counter, ones fill
// (RULE10) vote samples seven, eight, nine
// (RULE11) bad start bit returns to hunting
// (RULE12) bits enter right; start at left ends
// (RULE13) 8-bit load gated by flag and stop
// (RULE14) 9-bit load gated by flag and ninth
// (RULE15) hunting resumes after frame either way
// (RULE16) 9-bit stop bit affects no data
// (RULE17) missing stop sets sticky framing error
// (RULE18) control bit 7 selects error or mode
// (RULE19) 9-bit address mode needs ninth and match
// (RULE20) 8-bit address mode needs stop and match
// (RULE21) given address: address masked by mask
// (RULE22) broadcast: address or mask, zeros ignored
// (RULE23) reset clears address and mask
// (RULE24) fixed mode rate follows baud doubler
// (RULE25) timer modes: overflow times doubler over 32
// (RULE26) one 16x tick for transmit and receive
`timescale 1ns/10ps
`default_nettype none

module uart_addr_match (
   // clock and reset
   input  wire logic        ref_clk_i,
   input  wire logic        rst_i,
   // avalon-mm slave
   input  wire logic [4:0]  address_i,
   input  wire logic        read_i,
   input  wire logic        write_i,
   input  wire logic [31:0] writedata_i,
   input  wire logic [3:0]  byteenable_i,
   output logic      [31:0] readdata_o,
   output logic             waitrequest_o,
   // rate source
   input  wire logic        timer_overflow_i,
   // serial pins
   input  wire logic        serial_in_pin_i,
   output logic             serial_out_pin_o
);

   uart_am_pkg::uart_state_t r;
   uart_am_pkg::uart_state_t next_r;
   logic                     tick16;

   ////////////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic majority(input logic a, input logic b, input logic c);
      majority = (a & b) | (a & c) | (b & c);
   endfunction

   function automatic logic [7:0] bit_reverse(input logic [7:0] v);
      logic [7:0] o;
      o = '0;
      for (int i = 0; i < 8; i++) begin
         o[i] = v[7 - i];
      end
      bit_reverse = o;
   endfunction

   // given address or broadcast address match
   function automatic logic addr_match(input logic [7:0] b, input logic [7:0] sa, input logic [7:0] sm);
      logic [7:0] bcast;
      logic       given_hit;
      logic       bcast_hit;
      bcast     = sa | sm;                           // [RULE22]
      given_hit = ((b ^ sa) & sm) == 8'h00;          // [RULE21]
      bcast_hit = (b & bcast) == bcast;              // [RULE22]
      addr_match = given_hit | bcast_hit;
   endfunction

   function automatic uart_am_pkg::serial_mode_t mode_of(input logic m0, input logic m1);
      mode_of = uart_am_pkg::serial_mode_t'({m0, m1});
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // shared oversampling tick

   uart_am_pkg::serial_mode_t mode;
   logic                      rate_src;
   logic                      ninebit;
   logic                      async_on;

   assign mode     = mode_of(r.mode_select_bit0, r.mode_select_bit1);
   assign ninebit  = (mode == uart_am_pkg::MODE_9FIXED) || (mode == uart_am_pkg::MODE_9VAR);
   assign async_on = (mode != uart_am_pkg::MODE_SHIFT);
   // fixed 9-bit mode counts system clocks, the rest count timer overflows [RULE8]
   assign rate_src = (mode == uart_am_pkg::MODE_9FIXED) ? 1'b1 : timer_overflow_i;

   uart_tick_gen u_tick (
      .ref_clk_i   (ref_clk_i),
      .rst_i       (rst_i),
      .src_pulse_i (rate_src),
      .halve_i     (~r.baud_doubler),
      .tick_o      (tick16)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // next-state logic

   always_comb begin
      logic       req;
      logic       wr_now;
      logic       tx_roll;
      logic       vote;
      logic [7:0] rx_byte;
      logic       accept;
      logic [7:0] wbyte;
      req     = read_i | write_i;
      wr_now  = write_i & r.ack & byteenable_i[0];
      tx_roll = 1'b0;
      vote    = 1'b0;
      rx_byte = 8'h00;
      accept  = 1'b0;
      wbyte   = writedata_i[7:0];
      next_r  = r;

      // bus slave: one wait state, then the answer stands for one edge
      next_r.ack    = req & ~r.ack;
      next_r.wait_q = ~(req & ~r.ack);
      if (req & ~r.ack & read_i) begin
         unique case (address_i)
            uart_am_pkg::OFF_SERIAL_CONTROL: begin
               next_r.rdata = {24'h000000,
                               r.error_flag_select ? r.framing_error_flag : r.mode_select_bit0,   // [RULE18]
                               r.mode_select_bit1, r.multiprocessor_address_enable, r.receive_enable,
                               r.transmit_ninth_bit, r.received_ninth_bit,
                               r.transmit_done_flag, r.receive_done_flag};
            end
            uart_am_pkg::OFF_SERIAL_DATA:   next_r.rdata = {24'h000000, r.rx_buffer};
            uart_am_pkg::OFF_POWER_CONTROL: next_r.rdata = {24'h000000, r.baud_doubler, r.error_flag_select, 6'h00};
            uart_am_pkg::OFF_SLAVE_ADDRESS: next_r.rdata = {24'h000000, r.slave_address};
            uart_am_pkg::OFF_SLAVE_MASK:    next_r.rdata = {24'h000000, r.slave_address_mask};
            default:                        next_r.rdata = 32'h00000000;
         endcase
      end

      if (wr_now) begin
         unique case (address_i)
            uart_am_pkg::OFF_SERIAL_CONTROL: begin
               if (r.error_flag_select) begin
                  next_r.framing_error_flag = wbyte[uart_am_pkg::SC_MODE0_OR_FE];   // [RULE17] [RULE18]
               end else begin
                  next_r.mode_select_bit0 = wbyte[uart_am_pkg::SC_MODE0_OR_FE];     // [RULE18]
               end
               next_r.mode_select_bit1              = wbyte[uart_am_pkg::SC_MODE1];
               next_r.multiprocessor_address_enable = wbyte[uart_am_pkg::SC_MP_ENABLE];
               next_r.receive_enable                = wbyte[uart_am_pkg::SC_RX_ENABLE];
               next_r.transmit_ninth_bit            = wbyte[uart_am_pkg::SC_TX_NINTH];
               next_r.received_ninth_bit            = wbyte[uart_am_pkg::SC_RX_NINTH];
               next_r.transmit_done_flag            = wbyte[uart_am_pkg::SC_TX_DONE];
               next_r.receive_done_flag             = wbyte[uart_am_pkg::SC_RX_DONE];
            end
            uart_am_pkg::OFF_SERIAL_DATA: begin
               // a write during a frame is dropped: reloading would corrupt the line
               if (r.tx_st == uart_am_pkg::TX_IDLE) begin
                  next_r.tx_req   = 1'b1;                                            // [RULE2]
                  next_r.tx_first = 1'b1;
                  // 8-bit: marker one above data; 9-bit: ninth bit above data
                  next_r.tx_sh    = {ninebit ? r.transmit_ninth_bit : 1'b1, wbyte};  // [RULE4] [RULE6]
               end
            end
            uart_am_pkg::OFF_POWER_CONTROL: begin
               next_r.baud_doubler      = wbyte[uart_am_pkg::PC_BAUD_DOUBLER];
               next_r.error_flag_select = wbyte[uart_am_pkg::PC_ERR_SELECT];
            end
            uart_am_pkg::OFF_SLAVE_ADDRESS: next_r.slave_address      = wbyte;
            uart_am_pkg::OFF_SLAVE_MASK:    next_r.slave_address_mask = wbyte;
            default: ;
         endcase
      end

      ////////////////////////////////////////////////////////////////////////////////
      // transmitter: bit times follow the free-running divide-by-16 counter

      if (tick16) begin
         next_r.tx_cnt = r.tx_cnt + 4'h1;                                           // [RULE26]
         tx_roll       = (r.tx_cnt == uart_am_pkg::CNT_LAST);
      end

      if (tx_roll) begin
         unique case (r.tx_st)
            uart_am_pkg::TX_IDLE: begin
               // start waits for the rollover, not the write [RULE2]
               if (r.tx_req & async_on) begin
                  next_r.tx_req = 1'b0;
                  next_r.tx_st  = uart_am_pkg::TX_START;
                  next_r.txd    = 1'b0;                                            // [RULE1] [RULE3]
               end
            end
            uart_am_pkg::TX_START: begin
               next_r.tx_st = uart_am_pkg::TX_DATA;
               next_r.txd   = r.tx_sh[0];                                          // [RULE3]
            end
            uart_am_pkg::TX_DATA: begin
               if (~r.tx_first && (r.tx_sh[8:1] == uart_am_pkg::TX_END_MARK)) begin
                  // last shift: line returns high as the stop bit [RULE4] [RULE7]
                  next_r.tx_sh              = {1'b0, r.tx_sh[8:1]};
                  next_r.txd                = 1'b1;
                  next_r.tx_st              = uart_am_pkg::TX_IDLE;
                  next_r.transmit_done_flag = 1'b1;
               end else begin
                  // first 9-bit shift clocks the stop one in, zeros afterwards [RULE6]
                  next_r.tx_sh    = {ninebit & r.tx_first, r.tx_sh[8:1]};          // [RULE4] [RULE5]
                  next_r.txd      = r.tx_sh[1];
                  next_r.tx_first = 1'b0;
               end
            end
            default: next_r.tx_st = uart_am_pkg::TX_IDLE;
         endcase
      end

      ////////////////////////////////////////////////////////////////////////////////
      // receiver

      if (tick16) begin
         next_r.rx_prev = serial_in_pin_i;
         unique case (r.rx_st)
            uart_am_pkg::RX_HUNT: begin
               if (r.receive_enable & async_on & r.rx_prev & ~serial_in_pin_i) begin
                  next_r.rx_cnt = 4'h0;                                            // [RULE9]
                  next_r.rx_sh  = uart_am_pkg::RX_SH_ONES;                         // [RULE9]
                  next_r.rx_st  = uart_am_pkg::RX_BITS;
               end
            end
            uart_am_pkg::RX_BITS, uart_am_pkg::RX_STOP: begin
               next_r.rx_cnt = r.rx_cnt + 4'h1;                                    // [RULE26]
               if (r.rx_cnt == uart_am_pkg::CNT_VOTE_A) begin
                  next_r.rx_votes[0] = serial_in_pin_i;                            // [RULE10]
               end
               if (r.rx_cnt == uart_am_pkg::CNT_VOTE_B) begin
                  next_r.rx_votes[1] = serial_in_pin_i;                            // [RULE10]
               end
               if (r.rx_cnt == uart_am_pkg::CNT_VOTE_C) begin
                  vote = majority(r.rx_votes[0], r.rx_votes[1], serial_in_pin_i);  // [RULE10]
                  if (r.rx_st == uart_am_pkg::RX_STOP) begin
                     // 9-bit stop only feeds the error flag [RULE16]
                     if (~vote) begin
                        next_r.framing_error_flag = 1'b1;                          // [RULE17]
                     end
                     next_r.rx_st = uart_am_pkg::RX_HUNT;                          // [RULE15]
                  end else if (r.rx_sh == uart_am_pkg::RX_SH_ONES) begin
                     if (vote) begin
                        next_r.rx_st = uart_am_pkg::RX_HUNT;                       // [RULE11]
                     end else begin
                        next_r.rx_sh = {r.rx_sh[7:0], vote};                       // [RULE11] [RULE12]
                     end
                  end else if (~r.rx_sh[8]) begin
                     // start bit reached the left end: this vote is the last bit [RULE12]
                     rx_byte = bit_reverse(r.rx_sh[7:0]);
                     next_r.rx_sh = {r.rx_sh[7:0], vote};
                     // vote is the stop bit in 8-bit mode, the ninth bit otherwise
                     accept = ~r.receive_done_flag &
                              (~r.multiprocessor_address_enable |
                               (vote & addr_match(rx_byte, r.slave_address, r.slave_address_mask)));
                                                                                   // [RULE13] [RULE14] [RULE19] [RULE20]
                     if (accept) begin
                        next_r.rx_buffer          = rx_byte;                       // [RULE1] [RULE5]
                        next_r.received_ninth_bit = vote;
                        next_r.receive_done_flag  = 1'b1;
                     end
                     if (ninebit) begin
                        next_r.rx_st = uart_am_pkg::RX_STOP;                       // [RULE15]
                     end else begin
                        if (~vote) begin
                           next_r.framing_error_flag = 1'b1;                       // [RULE17]
                        end
                        next_r.rx_st = uart_am_pkg::RX_HUNT;                       // [RULE15]
                     end
                  end else begin
                     next_r.rx_sh = {r.rx_sh[7:0], vote};                          // [RULE12]
                  end
               end
            end
            default: next_r.rx_st = uart_am_pkg::RX_HUNT;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         r <= uart_am_pkg::STATE_RESET;                                            // [RULE23] [RULE24]
      end else begin
         r <= next_r;
      end
   end

   assign readdata_o       = r.rdata;
   assign waitrequest_o    = r.wait_q;
   assign serial_out_pin_o = r.txd;

endmodule // uart_addr_match

`default_nettype wire

// *** uart_am_monitor.sv ***
// checker for uart_addr_match: bus handshake, line timing, slave address reset value.
// assumes it is bound to the top module and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module uart_am_monitor (
   // clock and reset
   input wire logic        ref_clk_i,
   input wire logic        rst_i,
   // bus
   input wire logic [4:0]  address_i,
   input wire logic        read_i,
   input wire logic        write_i,
   input wire logic [31:0] readdata_o,
   input wire logic        waitrequest_o,
   // line
   input wire logic        serial_out_pin_o
);
   ////////////////////////////////////////////////////////////
   logic       acc;
   logic       dat_wr;
   logic       addr_wr;
   logic       wr_seen;
   logic [9:0] since_wr;
   assign acc = (read_i | write_i) & !waitrequest_o;
   assign dat_wr = acc & write_i & (address_i == uart_am_pkg::OFF_SERIAL_DATA);
   // conservative: any write attempt counts, ignored ones only relax the checks
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         addr_wr <= 1'b0;
         wr_seen <= 1'b0;
         since_wr <= 10'h3ff;
      end else begin
         addr_wr <= addr_wr | (acc & write_i & (address_i == uart_am_pkg::OFF_SLAVE_ADDRESS));
         wr_seen <= wr_seen | dat_wr;
         since_wr <= dat_wr ? 10'h000 : (since_wr == 10'h3ff ? since_wr : since_wr + 10'h001);
      end
   end
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   a_start_min_len: assert property ($fell(serial_out_pin_o) |-> !serial_out_pin_o [*8])
      else $error("line low for under eight clocks");
   a_high_min_len: assert property ($rose(serial_out_pin_o) |-> serial_out_pin_o [*8])
      else $error("line high for under eight clocks");
   a_idle_no_write: assert property (!wr_seen |-> serial_out_pin_o)
      else $error("line left idle without a data write");
   a_fall_after_write: assert property ($fell(serial_out_pin_o) |-> since_wr < 10'd400)
      else $error("line activity long after the last data write");
   a_wait_one: assert property ($rose(read_i | write_i) |=> !waitrequest_o)
      else $error("no answer one cycle after request");
   a_wait_single: assert property (!waitrequest_o |=> waitrequest_o)
      else $error("waitrequest low for more than one cycle");
   a_upper_zero: assert property (acc && read_i |-> readdata_o[31:8] == 24'h0)
      else $error("upper read data not zero");
   a_addr_reset: assert property (acc && read_i && address_i == uart_am_pkg::OFF_SLAVE_ADDRESS && !addr_wr
      |-> readdata_o == 32'h0)
      else $error("slave address not zero after reset");
   c_tx_start: cover property ($fell(serial_out_pin_o));
   c_data_write: cover property (dat_wr);
   c_addr_read: cover property (acc && read_i && address_i == uart_am_pkg::OFF_SLAVE_ADDRESS);
endmodule // uart_am_monitor
bind uart_addr_match uart_am_monitor mon_u (
   .ref_clk_i(ref_clk_i), .rst_i(rst_i), .address_i(address_i), .read_i(read_i), .write_i(write_i),
   .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .serial_out_pin_o(serial_out_pin_o));
`default_nettype wire

// *** uart_am_node.sv ***
// remote serial node: sends frames on the receive line, captures frames from the transmit line.
// assumes frames are given lsb first with start and stop bits included.
`timescale 1ns/10ps
`default_nettype none
module uart_am_node (
   // clock
   input  wire logic clk_i,
   // line
   input  wire logic tx_i,
   output logic      rx_o
);
   ////////////////////////////////////////////////////////////
   initial rx_o = 1'b1;
   // line returns to idle high, as with the usual pull-up
   task automatic send(input logic [10:0] bits, input int n, input int bt);
      for (int i = 0; i < n; i++) begin
         rx_o <= bits[i];
         repeat (bt) @(posedge clk_i);
      end
      rx_o <= 1'b1;
   endtask
   // mid-bit sampling, so a one-clock skew at the edges does not matter
   task automatic recv(output logic [10:0] got, input int n, input int bt);
      got = '0;
      @(negedge tx_i);
      repeat (bt / 2) @(posedge clk_i);
      for (int i = 0; i < n; i++) begin
         got[i] = tx_i;
         repeat (bt) @(posedge clk_i);
      end
   endtask
endmodule // uart_am_node
`default_nettype wire

// *** uart_am_pkg.sv ***
// package for the address-matching async serial port: register map, field positions,
// reset values, timing counts, modes, states and the packed state records.
// assumes a 32-bit avalon-mm slave with registers in the low byte lane.
package uart_am_pkg;

   // register byte offsets, one aligned word each
   localparam logic [4:0] OFF_SERIAL_CONTROL = 5'h00;
   localparam logic [4:0] OFF_SERIAL_DATA    = 5'h04;
   localparam logic [4:0] OFF_POWER_CONTROL  = 5'h08;
   localparam logic [4:0] OFF_SLAVE_ADDRESS  = 5'h0c;
   localparam logic [4:0] OFF_SLAVE_MASK     = 5'h10;

   // serial_control_register fields
   localparam int SC_MODE0_OR_FE = 7;
   localparam int SC_MODE1       = 6;
   localparam int SC_MP_ENABLE   = 5;
   localparam int SC_RX_ENABLE   = 4;
   localparam int SC_TX_NINTH    = 3;
   localparam int SC_RX_NINTH    = 2;
   localparam int SC_TX_DONE     = 1;
   localparam int SC_RX_DONE     = 0;

   // power_control_register fields
   localparam int PC_BAUD_DOUBLER = 7;
   localparam int PC_ERR_SELECT   = 6;

   // reset values
   localparam logic [7:0] SLAVE_ADDRESS_RESET = 8'h00;
   localparam logic [7:0] SLAVE_MASK_RESET    = 8'h00;

   // bit timing in oversampling ticks
   localparam logic [3:0] CNT_LAST     = 4'hf;
   localparam logic [3:0] CNT_VOTE_A   = 4'h7;
   localparam logic [3:0] CNT_VOTE_B   = 4'h8;
   localparam logic [3:0] CNT_VOTE_C   = 4'h9;
   localparam logic [8:0] RX_SH_ONES   = 9'h1ff;
   localparam logic [7:0] TX_END_MARK  = 8'h01;

   typedef enum logic [1:0] {
      MODE_SHIFT,
      MODE_8BIT,
      MODE_9FIXED,
      MODE_9VAR
   } serial_mode_t;

   typedef enum logic [1:0] {
      TX_IDLE,
      TX_START,
      TX_DATA
   } tx_state_t;

   typedef enum logic [1:0] {
      RX_HUNT,
      RX_BITS,
      RX_STOP
   } rx_state_t;

   typedef struct packed {
      // software-visible bits
      logic         mode_select_bit0;
      logic         mode_select_bit1;
      logic         multiprocessor_address_enable;
      logic         receive_enable;
      logic         transmit_ninth_bit;
      logic         received_ninth_bit;
      logic         transmit_done_flag;
      logic         receive_done_flag;
      logic         framing_error_flag;
      logic         baud_doubler;
      logic         error_flag_select;
      logic [7:0]   slave_address;
      logic [7:0]   slave_address_mask;
      logic [7:0]   rx_buffer;
      // transmitter
      tx_state_t    tx_st;
      logic         tx_req;
      logic [3:0]   tx_cnt;
      logic [8:0]   tx_sh;
      logic         tx_first;
      logic         txd;
      // receiver
      rx_state_t    rx_st;
      logic [3:0]   rx_cnt;
      logic [8:0]   rx_sh;
      logic         rx_prev;
      logic [1:0]   rx_votes;
      // bus slave
      logic         ack;
      logic         wait_q;
      logic [31:0]  rdata;
   } uart_state_t;

   localparam uart_state_t STATE_RESET = '{
      tx_st              : TX_IDLE,
      rx_st              : RX_HUNT,
      txd                : 1'b1,
      rx_prev            : 1'b1,
      wait_q             : 1'b1,
      slave_address      : SLAVE_ADDRESS_RESET,
      slave_address_mask : SLAVE_MASK_RESET,
      default            : '0
   };

   typedef struct packed {
      logic half;
      logic tick;
   } tick_state_t;

endpackage

// *** uart_tick_gen.sv ***
// oversampling tick source: passes or halves a rate pulse into one 16x-bit-rate tick.
// assumes src_pulse_i is a one-cycle pulse in the ref_clk_i domain.
`timescale 1ns/10ps
`default_nettype none

module uart_tick_gen (
   // clock and reset
   input  wire logic ref_clk_i,
   input  wire logic rst_i,
   // rate control
   input  wire logic src_pulse_i,
   input  wire logic halve_i,
   // tick out
   output logic      tick_o
);

   uart_am_pkg::tick_state_t r;
   uart_am_pkg::tick_state_t next_r;

   always_comb begin
      next_r      = r;
      next_r.tick = 1'b0;
      if (src_pulse_i) begin
         // halving gives the /32 bit rate, passing gives /16 [RULE24] [RULE25]
         next_r.half = halve_i ? ~r.half : 1'b0;
         next_r.tick = halve_i ? r.half : 1'b1;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign tick_o = r.tick;

endmodule // uart_tick_gen

`default_nettype wire
